// *** pkg/ocl_map.svh ***
// Command codes, field positions, fuse defaults and timing for the fuse calibration link.
// Included by both ends; holds definitions only.
`ifndef OCL_MAP_SVH
`define OCL_MAP_SVH

`define OCL_CMD_CALIB 8'hF0
`define OCL_CMD_SHIFT 8'hF1
`define OCL_CMD_WAKE 8'h11
// Factory default select is 7'h77 in bits 7..1, the select value in bit 0.
`define OCL_CMD_SFD_HI 7'h77

`define OCL_CAL_FLAG_BIT 0
`define OCL_CAL_OPE_BIT 1
`define OCL_CAL_ROW_LSB 3
`define OCL_CAL_ROW_MSB 5

`define OCL_ROWS 7
`define OCL_COLS 16
`define OCL_SEAL_COL 0
`define OCL_SEAL_ROW 0
`define OCL_EFD_COL 14
`define OCL_EFD_ROW 0

// Unprogrammed cell values, one byte per column, column 15 leftmost, bit n is row n.
`define OCL_FUSE_DEFAULT 128'h3C2C132C013D1C3C070023191E233800

`define OCL_CLK_MHZ 10
`define OCL_REFRESH_TIME_US 1000

`endif

// *** pkg/ocl_pkg.sv ***
// Types shared by the host end and the device end of the fuse calibration link.
// Assumes nothing of its surroundings.
package ocl_pkg;

  typedef logic [7:0] ocl_byte_t;

  typedef enum logic [1:0] {
    OCL_ST_IDLE = 2'b00,
    OCL_ST_PARAM = 2'b01,
    OCL_ST_SHIFT = 2'b10
  } ocl_state_t;

  typedef enum logic [2:0] {
    OCL_OP_RAW_CMD = 3'b000,
    OCL_OP_RAW_DATA = 3'b001,
    OCL_OP_CALIB = 3'b010,
    OCL_OP_WAKE = 3'b011,
    OCL_OP_SHIFT_CMD = 3'b100,
    OCL_OP_SHIFT_DATA = 3'b101,
    OCL_OP_SFD = 3'b110
  } ocl_op_t;

endpackage

// *** pkg/ocl_if.sv ***
// Byte link between the host processor and the driver: one byte with its data/command level,
// and a valid/ready handshake. Both ends run on the same clock, supplied by the testbench.
`timescale 1ns/100ps
interface ocl_if;
  logic [7:0] byte_data;
  logic dc;
  logic valid;
  logic ready;

  modport host (
    output byte_data,
    output dc,
    output valid,
    input ready
  );

  modport dev (
    input byte_data,
    input dc,
    input valid,
    output ready
  );
endinterface

// *** logic/ocl_host.sv ***
// Host end: turns user operations into command and parameter bytes on the link.
// Assumes the device end on the same clock and a user that holds an operation until taken.
`timescale 1ns/100ps
`include "ocl_map.svh"
module ocl_host (
  input wire logic core_clk_in,
  input wire logic reset_in,
  ocl_if.host link,
  input wire logic op_valid_in,
  input wire ocl_pkg::ocl_op_t op_code_in,
  input wire ocl_pkg::ocl_byte_t op_arg_in,
  output logic op_ready_out
);
  import ocl_pkg::*;

  logic valid_q;
  logic valid_d;
  logic ready_q;
  logic [8:0] word_q;
  logic take;
  logic sent;

  // Returns the data/command level in bit 8 and the byte below it.
  function automatic logic [8:0] ocl_format(input ocl_op_t op, input ocl_byte_t arg);
    logic [8:0] w;
    w = {1'b0, arg};
    unique case (op)
      OCL_OP_RAW_CMD: w = {1'b0, arg};
      OCL_OP_RAW_DATA: w = {1'b1, arg};
      // Argument bit 4 is the calibration flag, bit 3 the switch enable, bits 2..0 the row.
      OCL_OP_CALIB: w = {1'b1, 2'b00, arg[2:0], 1'b0, arg[3], arg[4]};
      OCL_OP_WAKE: w = {1'b0, `OCL_CMD_WAKE};
      OCL_OP_SHIFT_CMD: w = {1'b0, `OCL_CMD_SHIFT};
      OCL_OP_SHIFT_DATA: w = {1'b1, 1'b0, arg[6:0]};
      OCL_OP_SFD: w = {1'b0, `OCL_CMD_SFD_HI, arg[0]};
      default: w = {1'b0, arg};
    endcase
    return w;
  endfunction

  assign take = op_valid_in && ready_q;
  assign sent = valid_q && link.ready;
  assign valid_d = take || (valid_q && !sent);

  // The calibration command byte goes out as a raw command; its parameter follows as OCL_OP_CALIB.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      valid_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
      ready_q <= !valid_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      word_q <= 9'h000;
    end else if (take) begin
      word_q <= ocl_format(op_code_in, op_arg_in);
    end
  end

  assign link.valid = valid_q;
  assign link.dc = word_q[8];
  assign link.byte_data = word_q[7:0];
  assign op_ready_out = ready_q;
endmodule

// *** logic/ocl_device.sv ***
// Device end: decodes fuse calibration commands, holds the fuse matrix registers, runs the
// refresh from the non-volatile cells and drives the programming switch and burn pattern.
// Assumes the host end on the same clock and a fuse macro that reports its burned cells.
// Function
// - F0 then parameter bit 0 sets calibration mode.
// - Shifting and burning only inside calibration mode.
// - Parameter bits 5..3 select the row to burn.
// - Programming switch closed only while enable bit set.
// - Wake command 11 starts refresh outside calibration.
// - Refresh loads every register from its cell.
// - Refresh lasts 1 ms; commands keep running.
// - No refresh start while calibration flag set.
// - F1 starts shifting; data bits 6..0 used.
// - Data bytes shift until a command byte.
// - New byte into column 0, others move up.
// - Bit 7 of shift data is dropped.
// - EE/EF set factory default select from bit 0.
// - Burning inverts the default, only once.
// - Programmed seal cell blocks calibration entry.
// - Matrix of 7 rows, column-parallel byte loading.
// - Factory default fuse forces fuse configuration.
`timescale 1ns/100ps
`include "ocl_map.svh"
module ocl_device #(
  parameter int unsigned ROWS = `OCL_ROWS,
  parameter int unsigned COLS = `OCL_COLS,
  parameter int unsigned REFRESH_CYCLES = `OCL_REFRESH_TIME_US * `OCL_CLK_MHZ
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  ocl_if.dev link,
  input wire logic drain_hold_in,
  input wire logic [COLS*ROWS-1:0] fuse_burned_in,
  output logic calib_mode_flag_out,
  output logic prog_switch_enable_out,
  output logic [2:0] prog_row_addr_out,
  output logic [COLS-1:0] burn_mask_out,
  output logic factory_default_select_out,
  output logic use_fuse_config_out,
  output logic refresh_busy_out,
  output logic [COLS*ROWS-1:0] fuse_regs_out
);
  import ocl_pkg::*;

  localparam int unsigned RW = $clog2(REFRESH_CYCLES + 1);
  localparam logic [127:0] DEFAULTS = `OCL_FUSE_DEFAULT;

  // Non-volatile value of one column: the fixed default, inverted where the cell is burned.
  function automatic logic [ROWS-1:0] nv_col(input int unsigned c,
                                             input logic [COLS*ROWS-1:0] burned);
    logic [ROWS-1:0] v;
    v = DEFAULTS[c*8 +: ROWS] ^ burned[c*ROWS +: ROWS];
    return v;
  endfunction

  logic [COLS*ROWS-1:0] burned_s1_q;
  logic [COLS*ROWS-1:0] burned_s2_q;

  logic [8:0] buf_q [2];
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic ready_q;
  logic wr;
  logic rd;
  logic rx_dc;
  logic [7:0] rx_byte;
  logic is_cmd;
  logic is_dat;

  ocl_state_t state_q;
  logic calib_q;
  logic ope_q;
  logic [2:0] row_q;
  logic switch_q;
  logic [COLS-1:0] burn_q;
  logic sfd_q;
  logic use_fuse_q;
  logic [RW-1:0] refresh_q;
  logic busy_q;
  logic refresh_done;
  logic refresh_start;
  logic seal;
  logic [ROWS-1:0] seal_col;
  logic efd;
  logic [ROWS-1:0] col_q [COLS];

  // The fuse macro is outside this clock's control, so its report is synchronised first.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      burned_s1_q <= '0;
      burned_s2_q <= '0;
    end else begin
      burned_s1_q <= fuse_burned_in;
      burned_s2_q <= burned_s1_q;
    end
  end

  // Two-entry buffer: a held drain fills it, and ready drops only when both entries are full.
  assign wr = link.valid && ready_q;
  assign rd = (cnt_q != 2'd0) && !drain_hold_in;
  assign cnt_d = cnt_q + {1'b0, wr} - {1'b0, rd};
  assign rx_dc = buf_q[rd_ptr_q][8];
  assign rx_byte = buf_q[rd_ptr_q][7:0];
  assign is_cmd = rd && !rx_dc;
  assign is_dat = rd && rx_dc;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cnt_q <= 2'd0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      wr_ptr_q <= wr_ptr_q ^ wr;
      rd_ptr_q <= rd_ptr_q ^ rd;
      ready_q <= (cnt_d != 2'd2);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      buf_q[0] <= 9'h000;
      buf_q[1] <= 9'h000;
    end else if (wr) begin
      buf_q[wr_ptr_q] <= {link.dc, link.byte_data};
    end
  end

  // A function result cannot be indexed directly, so the seal column is named first.
  assign seal_col = nv_col(`OCL_SEAL_COL, burned_s2_q);
  assign seal = seal_col[`OCL_SEAL_ROW];
  assign efd = col_q[`OCL_EFD_COL][`OCL_EFD_ROW];

  // Command decoding. Any command byte ends a parameter wait or a shift run.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_q <= OCL_ST_IDLE;
    end else if (is_cmd) begin
      if (rx_byte == `OCL_CMD_CALIB) begin
        state_q <= OCL_ST_PARAM;
      end else if (rx_byte == `OCL_CMD_SHIFT && calib_q) begin
        state_q <= OCL_ST_SHIFT;
      end else begin
        state_q <= OCL_ST_IDLE;
      end
    end else if (is_dat) begin
      unique case (state_q)
        OCL_ST_IDLE: state_q <= OCL_ST_IDLE;
        OCL_ST_PARAM: state_q <= OCL_ST_IDLE;
        OCL_ST_SHIFT: state_q <= calib_q ? OCL_ST_SHIFT : OCL_ST_IDLE;
        default: state_q <= OCL_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      calib_q <= 1'b0;
      ope_q <= 1'b0;
      row_q <= 3'd0;
    end else if (is_dat && state_q == OCL_ST_PARAM) begin
      // Leaving is always allowed; entry is refused once the seal cell is burned.
      calib_q <= rx_byte[`OCL_CAL_FLAG_BIT] && !seal;
      ope_q <= rx_byte[`OCL_CAL_OPE_BIT];
      row_q <= rx_byte[`OCL_CAL_ROW_MSB:`OCL_CAL_ROW_LSB];
    end
  end

  // The switch and burn pattern lag the parameter byte by one cycle; rows past the last read 0.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      switch_q <= 1'b0;
      burn_q <= '0;
    end else begin
      switch_q <= calib_q && ope_q;
      for (int unsigned c = 0; c < COLS; c++) begin
        burn_q[c] <= calib_q && ope_q && (32'(row_q) < ROWS) && col_q[c][row_q];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sfd_q <= 1'b0;
    end else if (is_cmd && rx_byte[7:1] == `OCL_CMD_SFD_HI) begin
      sfd_q <= rx_byte[0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      use_fuse_q <= 1'b0;
    end else begin
      use_fuse_q <= efd || sfd_q;
    end
  end

  // A refresh also runs after reset. It only counts down, so commands are never stalled by it.
  assign refresh_start = is_cmd && rx_byte == `OCL_CMD_WAKE && !calib_q;
  assign refresh_done = (refresh_q == RW'(1));

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      refresh_q <= RW'(REFRESH_CYCLES);
      busy_q <= 1'b1;
    end else if (refresh_start) begin
      refresh_q <= RW'(REFRESH_CYCLES);
      busy_q <= 1'b1;
    end else if (refresh_q != RW'(0)) begin
      refresh_q <= refresh_q - RW'(1);
      busy_q <= !refresh_done;
    end
  end

  // Column registers: the refresh load takes the place of a shift landing in the same cycle.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      for (int unsigned c = 0; c < COLS; c++) begin
        col_q[c] <= DEFAULTS[c*8 +: ROWS];
      end
    end else if (refresh_done && !refresh_start) begin
      for (int unsigned c = 0; c < COLS; c++) begin
        col_q[c] <= nv_col(c, burned_s2_q);
      end
    end else if (is_dat && state_q == OCL_ST_SHIFT && calib_q) begin
      col_q[0] <= rx_byte[ROWS-1:0];
      for (int unsigned c = 1; c < COLS; c++) begin
        col_q[c] <= col_q[c-1];
      end
    end
  end

  for (genvar g = 0; g < COLS; g++) begin : g_regs
    assign fuse_regs_out[g*ROWS +: ROWS] = col_q[g];
  end

  assign link.ready = ready_q;
  assign calib_mode_flag_out = calib_q;
  assign prog_switch_enable_out = switch_q;
  assign prog_row_addr_out = row_q;
  assign burn_mask_out = burn_q;
  assign factory_default_select_out = sfd_q;
  assign use_fuse_config_out = use_fuse_q;
  assign refresh_busy_out = busy_q;
endmodule

// *** dv/ocl_link_props.sv ***
// Checker for the fuse calibration link and the device outputs.
// Assumes one clock domain and the synchronous reset of both ends.
`timescale 1ns/100ps
`include "ocl_map.svh"
module ocl_link_props #(
  parameter int unsigned ROWS = 7,
  parameter int unsigned COLS = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] byte_data,
  input wire logic dc,
  input wire logic valid,
  input wire logic ready,
  input wire logic calib_mode_flag_out,
  input wire logic prog_switch_enable_out,
  input wire logic [2:0] prog_row_addr_out,
  input wire logic [COLS-1:0] burn_mask_out,
  input wire logic factory_default_select_out,
  input wire logic use_fuse_config_out,
  input wire logic refresh_busy_out,
  input wire logic [COLS*ROWS-1:0] fuse_regs_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);
  a_valid_holds: assert property (valid && !ready |=> valid && $stable(byte_data) && $stable(dc))
    else $error("byte changed before it was taken");
  a_switch_mode: assert property (prog_switch_enable_out |-> $past(calib_mode_flag_out))
    else $error("switch closed outside calibration");
  a_burn_gated: assert property (burn_mask_out != '0 |-> prog_switch_enable_out)
    else $error("burn pattern with switch open");
  a_reset_clear: assert property ($fell(reset_in) |-> !calib_mode_flag_out
    && !prog_switch_enable_out && prog_row_addr_out == 3'h0)
    else $error("state not cleared by reset");
  a_fuse_forces: assert property (!$past(reset_in) |-> use_fuse_config_out ==
    ($past(fuse_regs_out[`OCL_EFD_COL*ROWS+`OCL_EFD_ROW]) || $past(factory_default_select_out)))
    else $error("configuration source wrong");
  a_no_cal_refresh: assert property ($rose(refresh_busy_out) |-> !$past(calib_mode_flag_out))
    else $error("refresh started in calibration");
  a_regs_cause: assert property ($changed(fuse_regs_out)
    |-> $past(calib_mode_flag_out) || $fell(refresh_busy_out))
    else $error("matrix changed without cause");
  a_shift_moves: assert property ($changed(fuse_regs_out) && !$fell(refresh_busy_out)
    |-> fuse_regs_out[COLS*ROWS-1:ROWS] == $past(fuse_regs_out[COLS*ROWS-ROWS-1:0]))
    else $error("columns did not move up");
  c_refresh: cover property ($rose(refresh_busy_out));
  c_switch: cover property ($rose(prog_switch_enable_out));
  c_full: cover property (valid && !ready);
endmodule

// *** dv/test_otp_calibration_command_logic.sv ***
// Bench for the host end and the device end joined by the link.
// Assumes package, header, interface and checker are compiled first.
`timescale 1ns/100ps
`include "ocl_map.svh"
module test_otp_calibration_command_logic;
  import ocl_pkg::*;
  localparam int unsigned ROWS = 7;
  localparam int unsigned COLS = 16;
  localparam int unsigned NB = ROWS*COLS;
  localparam logic [NB-1:0] BURN = 112'h6;
  localparam logic [127:0] DT = `OCL_FUSE_DEFAULT;
  typedef struct {ocl_op_t c; ocl_byte_t a; logic [5:0] e;} ocl_row_t;
  // Expected value is {flag, switch, row, select}.
  ocl_row_t rows [8] = '{'{OCL_OP_RAW_CMD, 8'hF0, 6'h00}, '{OCL_OP_CALIB, 8'h1D, 6'h3A},
    '{OCL_OP_SFD, 8'h01, 6'h3B}, '{OCL_OP_SFD, 8'h00, 6'h3A}, '{OCL_OP_RAW_CMD, 8'hF0, 6'h3A},
    '{OCL_OP_CALIB, 8'h12, 6'h24}, '{OCL_OP_RAW_CMD, 8'hF0, 6'h24}, '{OCL_OP_CALIB, 8'h00, 6'h00}};
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic op_valid = 1'b0;
  ocl_op_t op_code = OCL_OP_RAW_CMD;
  ocl_byte_t op_arg = 8'h00;
  logic hold = 1'b0;
  logic [NB-1:0] burned = BURN;
  logic op_ready, flag, sw, sel, use_fuse, busy;
  logic [2:0] row;
  logic [COLS-1:0] burn_mask;
  logic [NB-1:0] regs, dflt, exp_regs;
  int n_errors = 0;
  int checks_done = 0;
  always #50 core_clk_in = ~core_clk_in;
  ocl_if link_if ();
  ocl_host u_ocl_host (.core_clk_in(core_clk_in), .reset_in(reset_in), .link(link_if),
    .op_valid_in(op_valid), .op_code_in(op_code), .op_arg_in(op_arg), .op_ready_out(op_ready));
  ocl_device #(.ROWS(ROWS), .COLS(COLS), .REFRESH_CYCLES(8)) u_ocl_device (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .link(link_if), .drain_hold_in(hold),
    .fuse_burned_in(burned), .calib_mode_flag_out(flag), .prog_switch_enable_out(sw),
    .prog_row_addr_out(row), .burn_mask_out(burn_mask), .factory_default_select_out(sel),
    .use_fuse_config_out(use_fuse), .refresh_busy_out(busy), .fuse_regs_out(regs));
  ocl_link_props #(.ROWS(ROWS), .COLS(COLS)) u_ocl_link_props (.core_clk_in(core_clk_in),
    .reset_in(reset_in), .byte_data(link_if.byte_data), .dc(link_if.dc),
    .valid(link_if.valid), .ready(link_if.ready), .calib_mode_flag_out(flag),
    .prog_switch_enable_out(sw), .prog_row_addr_out(row), .burn_mask_out(burn_mask),
    .factory_default_select_out(sel), .use_fuse_config_out(use_fuse),
    .refresh_busy_out(busy), .fuse_regs_out(regs));
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [NB-1:0] seen, input logic [NB-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Gathers one row of the matrix across all columns, as the burn pattern presents it.
  function automatic logic [COLS-1:0] row_bits(input logic [NB-1:0] r, input int unsigned k);
    logic [COLS-1:0] m;
    for (int c = 0; c < COLS; c++) m[c] = r[c*ROWS+k];
    return m;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  // Returns four cycles after the host took the operation, so its effects have landed.
  task automatic op(input ocl_op_t c, input ocl_byte_t a);
    int i;
    op_code = c;
    op_arg = a;
    op_valid = 1'b1;
    for (i = 0; i < 50 && op_ready !== 1'b1; i++) tick(1);
    if (op_ready !== 1'b1) begin
      n_errors++;
      complete_run();
    end
    tick(1);
    op_valid = 1'b0;
    tick(4);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 20 && busy !== 1'b0; i++) tick(1);
    if (busy !== 1'b0) begin
      n_errors++;
      complete_run();
    end
  endtask
  initial begin
    for (int i = 0; i < NB; i++) dflt[i] = DT[(i/ROWS)*8+i%ROWS];
    tick(4);
    reset_in = 1'b0;
    chk({flag, sw, row}, 0);
    chk(regs, dflt);
    tick(12);
    chk(regs, dflt ^ BURN);
    $display("reset and refresh done");
    for (int i = 0; i < 8; i++) begin
      op(rows[i].c, rows[i].a);
      chk({flag, sw, row, sel}, rows[i].e);
      chk(burn_mask, rows[i].e[4] ? row_bits(dflt ^ BURN, rows[i].e[3:1]) : '0);
    end
    $display("table done");
    op(OCL_OP_RAW_CMD, 8'hF0);
    op(OCL_OP_CALIB, 8'h10);
    op(OCL_OP_SHIFT_CMD, 8'h00);
    op(OCL_OP_RAW_DATA, 8'hAA);
    op(OCL_OP_SHIFT_DATA, 8'h55);
    exp_regs = {dflt[NB-15:0] ^ BURN[NB-15:0], 7'h2A, 7'h55};
    chk(regs, exp_regs);
    op(OCL_OP_WAKE, 8'h00);
    chk(busy, 1'b0);
    op(OCL_OP_RAW_DATA, 8'h33);
    chk(regs, exp_regs);
    op(OCL_OP_RAW_CMD, 8'hF0);
    op(OCL_OP_CALIB, 8'h00);
    op(OCL_OP_SHIFT_DATA, 8'h11);
    chk(regs, exp_regs);
    op(OCL_OP_WAKE, 8'h00);
    chk(busy, 1'b1);
    op(OCL_OP_SFD, 8'h01);
    chk(sel, 1'b1);
    wait_idle();
    chk(regs, dflt ^ BURN);
    op(OCL_OP_SFD, 8'h00);
    $display("shift and refresh done");
    hold = 1'b1;
    op(OCL_OP_SFD, 8'h01);
    op(OCL_OP_SFD, 8'h00);
    op(OCL_OP_SFD, 8'h01);
    chk(link_if.ready, 1'b0);
    chk(sel, 1'b0);
    hold = 1'b0;
    tick(8);
    chk(sel, 1'b1);
    op(OCL_OP_SFD, 8'h00);
    $display("buffer stall done");
    burned[`OCL_EFD_COL*ROWS+`OCL_EFD_ROW] = 1'b1;
    tick(3);
    op(OCL_OP_WAKE, 8'h00);
    wait_idle();
    op(OCL_OP_SFD, 8'h00);
    chk(use_fuse, 1'b1);
    burned[`OCL_SEAL_COL*ROWS+`OCL_SEAL_ROW] = 1'b1;
    tick(3);
    op(OCL_OP_RAW_CMD, 8'hF0);
    op(OCL_OP_CALIB, 8'h10);
    chk(flag, 1'b0);
    $display("fuse and seal done");
    complete_run();
  end
endmodule
